/* File: pkg/chgmf_defs.svh */
// Constants for the charger mode and fault control block.
`ifndef CHGMF_DEFS_SVH
`define CHGMF_DEFS_SVH
`define CHGMF_CLK_HZ 20000000
`define CHGMF_INT_PULSE_NS 128000
`define CHGMF_INT_PULSE_CYC ((`CHGMF_INT_PULSE_NS * (`CHGMF_CLK_HZ / 1000000)) / 1000)
`define CHGMF_DGL_OVP_CYC 2560
`define CHGMF_DGL_INPUT_UNDERVOLTAGE_CYC 2560
`define CHGMF_DPM_SEL_W 3
`define CHGMF_DPM_MIN_MV 4200
`define CHGMF_DPM_STEP_MV 100
`define CHGMF_TERM_W 7
`define CHGMF_TERM_MIN_UA 500
`define CHGMF_TERM_STEP_UA 500
`define CHGMF_TERM_MAX_CODE 7'h49
`define CHGMF_TERM_DEF_CODE 7'h13
`define CHGMF_PCT_W 2
`endif

/* File: pkg/chgmf_pkg.sv */
// Types for the charger mode and fault control block.
package chgmf_pkg;
	typedef enum logic [1:0] {CHGMF_LOOP_CC, CHGMF_LOOP_CV, CHGMF_LOOP_INPUT_CURRENT_LIMIT_SETTING, CHGMF_LOOP_OTHER}
		chgmf_loop_t;
	typedef enum logic [2:0] {CHGMF_ST_IDLE, CHGMF_ST_CHARGE, CHGMF_ST_DONE, CHGMF_ST_HOLD,
		CHGMF_ST_FAULT} chgmf_state_t;
endpackage

/* File: hw/chgmf_deglitch.sv */
// Synchroniser with qualification counter for one comparator level.
`timescale 1ns/1ps
`default_nettype none
module chgmf_deglitch #(
	parameter int CYC = 2560
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Raw level and qualified result
	input wire logic raw_i,
	output logic level_o
);
	logic s1_q;
	logic s2_q;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	wire logic differs;
	wire logic done;
	assign differs = s2_q != level_o;
	assign done = cnt_q >= 16'(CYC - 1);
	assign cnt_d = (!differs || done) ? 16'h0000 : cnt_q + 16'h0001;
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			cnt_q <= 16'h0000;
			level_o <= 1'b0;
		end
		else
		begin
			s1_q <= raw_i;
			s2_q <= s1_q;
			cnt_q <= cnt_d;
			if (differs && done)
				level_o <= s2_q;
		end
	end
endmodule
`default_nettype wire

/* File: hw/chgmf_top.sv */
// Charger mode, termination and input fault control logic.
//
// Overview of operation
// - Input power-management threshold selects 4.2 V to 4.9 V in 100 mV steps, or off.
// - Active input power-management loop sets the input voltage limit flag.
// - Double timer option extends safety timer while input power management is active.
// - Input power management active inhibits charge termination.
// - Input between undervoltage and threshold with a battery attached: no charging, middle node fed by battery.
// - Overvoltage turns discharge switch on, one 128 us interrupt pulse, flags updated.
// - After overvoltage clears and deglitch passes, status clears and operation resumes.
// - Fault flags stay until read after the condition has gone.
// - Undervoltage after deglitch: fault, one 128 us pulse, status and flags updated.
// - Valid input and charge disable 0 starts charge; 1 keeps discharge switch off.
// - Charge disable pin also enables or disables charging.
// - Termination in constant-voltage mode at threshold current above recharge level.
// - Termination blocked when any loop other than constant voltage controls.
// - Supplement mode entered below battery by entry offset, left above by exit offset.
// - No termination in power-path reduction or supplement mode.
// - Default mode on valid input arrival or reset bit; left on any host write.
// - Default mode with a grounded programming pin uses built-in settings.
// - Termination current register spans 500 uA to 37 mA.
// - Resistor termination is 5 to 20 percent of fast charge; precharge equals it.
// - Host mode uses external termination when the setting selects it.
`timescale 1ns/1ps
`default_nettype none
`include "chgmf_defs.svh"
module chgmf_top #(
	parameter int PULSE_CYC = `CHGMF_INT_PULSE_CYC,
	parameter int DGL_OVP_CYC = `CHGMF_DGL_OVP_CYC,
	parameter int DGL_INPUT_UNDERVOLTAGE_CYC = `CHGMF_DGL_INPUT_UNDERVOLTAGE_CYC
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Analog comparator levels, asynchronous
	input wire logic input_overvoltage_i,
	input wire logic input_undervoltage_i,
	input wire logic input_below_dpm_i,
	input wire logic battery_attached_i,
	input wire logic mid_below_bat_entry_i,
	input wire logic mid_above_bat_exit_i,
	input wire logic power_path_reduction_mode_i,
	input wire logic current_at_term_i,
	input wire logic bat_above_recharge_i,
	input wire logic [1:0] active_loop_i,
	input wire logic charge_disable_pin_i,
	input wire logic prog_pin_grounded_i,
	// Register bits from the host interface logic
	input wire logic host_write_i,
	input wire logic fault_read_i,
	input wire logic reset_bit_i,
	input wire logic charge_disable_bit_i,
	input wire logic dpm_disable_i,
	input wire logic [`CHGMF_DPM_SEL_W-1:0] dpm_sel_i,
	input wire logic term_enable_i,
	input wire logic double_timer_i,
	input wire logic [`CHGMF_TERM_W-1:0] term_code_i,
	input wire logic use_ext_term_i,
	input wire logic [`CHGMF_PCT_W-1:0] ext_term_pct_i,
	// Outputs
	output logic [`CHGMF_DPM_SEL_W-1:0] dpm_thresh_sel_o,
	output logic dpm_active_o,
	output logic input_voltage_limit_flag_o,
	output logic timer_extend_o,
	output logic charge_enable_o,
	output logic discharge_switch_o,
	output logic supplement_mode_o,
	output logic term_done_o,
	output logic default_mode_o,
	output logic use_builtin_o,
	output logic [`CHGMF_TERM_W-1:0] term_code_o,
	output logic [`CHGMF_TERM_W-1:0] precharge_code_o,
	output logic ext_term_o,
	output logic [`CHGMF_PCT_W-1:0] ext_term_pct_o,
	output logic ovp_status_o,
	output logic input_undervoltage_status_o,
	output logic ovp_fault_o,
	output logic input_undervoltage_fault_o,
	output logic int_o
);
	import chgmf_pkg::*;

	localparam int PULSE_CNT = (PULSE_CYC < 1) ? 1 : PULSE_CYC;

	// Raw comparator levels pass two flops before use.
	logic [10:0] s1_q;
	logic [10:0] s2_q;
	logic ovp_q;
	logic input_undervoltage_q;
	logic ovp_prev_q;
	logic input_undervoltage_prev_q;
	logic valid_prev_q;
	logic [12:0] pulse_cnt_q;
	chgmf_state_t state_q;
	chgmf_state_t state_d;

	chgmf_deglitch #(.CYC(DGL_OVP_CYC)) u_dgl_ovp (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.raw_i(input_overvoltage_i),
		.level_o(ovp_q)
	);
	chgmf_deglitch #(.CYC(DGL_INPUT_UNDERVOLTAGE_CYC)) u_dgl_input_undervoltage (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.raw_i(input_undervoltage_i),
		.level_o(input_undervoltage_q)
	);

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			s1_q <= 11'h000;
			s2_q <= 11'h000;
		end
		else
		begin
			s1_q <= {prog_pin_grounded_i, charge_disable_pin_i, active_loop_i,
				bat_above_recharge_i, current_at_term_i, power_path_reduction_mode_i,
				mid_above_bat_exit_i, mid_below_bat_entry_i, battery_attached_i,
				input_below_dpm_i};
			s2_q <= s1_q;
		end
	end

	wire logic below_dpm = s2_q[0];
	wire logic bat_att = s2_q[1];
	wire logic sup_enter = s2_q[2];
	wire logic sup_exit = s2_q[3];
	wire logic power_path_reduction_mode = s2_q[4];
	wire logic at_term = s2_q[5];
	wire logic above_rchg = s2_q[6];
	wire logic [1:0] loop_s = s2_q[8:7];
	wire logic cd_pin = s2_q[9];
	wire logic pin_gnd = s2_q[10];

	// Loop is active only when the function is enabled and the input sits below threshold.
	wire logic dpm_act = !dpm_disable_i && below_dpm && !input_undervoltage_q;
	wire logic input_valid = !ovp_q && !input_undervoltage_q;
	wire logic chg_off = charge_disable_bit_i || cd_pin;
	wire logic no_chg_window = dpm_act && bat_att;
	wire logic cv_only = loop_s == CHGMF_LOOP_CV;
	wire logic term_block = dpm_act || power_path_reduction_mode || supplement_mode_o || !cv_only;
	wire logic term_hit = term_enable_i && !term_block && at_term && above_rchg;
	wire logic ovp_rise = ovp_q && !ovp_prev_q;
	wire logic input_undervoltage_rise = input_undervoltage_q && !input_undervoltage_prev_q;
	wire logic pulse_busy = pulse_cnt_q != 13'h0000;
	wire logic fault_event = ovp_rise || input_undervoltage_rise;
	// Any code above the top step saturates at 37 mA.
	wire logic [`CHGMF_TERM_W-1:0] term_clip =
		(term_code_i > `CHGMF_TERM_MAX_CODE) ? `CHGMF_TERM_MAX_CODE : term_code_i;
	wire logic [`CHGMF_TERM_W-1:0] term_sel =
		(default_mode_o && pin_gnd) ? `CHGMF_TERM_DEF_CODE : term_clip;
	wire logic ext_sel = default_mode_o ? !pin_gnd : use_ext_term_i;

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			CHGMF_ST_IDLE:
				if (!input_valid)
					state_d = CHGMF_ST_FAULT;
				else if (!chg_off && !no_chg_window)
					state_d = CHGMF_ST_CHARGE;
				else
					state_d = CHGMF_ST_HOLD;
			CHGMF_ST_CHARGE:
				if (!input_valid)
					state_d = CHGMF_ST_FAULT;
				else if (chg_off || no_chg_window)
					state_d = CHGMF_ST_HOLD;
				else if (term_hit)
					state_d = CHGMF_ST_DONE;
			CHGMF_ST_DONE:
				if (!input_valid)
					state_d = CHGMF_ST_FAULT;
				else if (chg_off)
					state_d = CHGMF_ST_HOLD;
			CHGMF_ST_HOLD:
				if (!input_valid)
					state_d = CHGMF_ST_FAULT;
				else if (!chg_off && !no_chg_window)
					state_d = CHGMF_ST_CHARGE;
			CHGMF_ST_FAULT:
				if (input_valid)
					state_d = CHGMF_ST_IDLE;
			default:
				state_d = CHGMF_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= CHGMF_ST_IDLE;
			ovp_prev_q <= 1'b0;
			input_undervoltage_prev_q <= 1'b0;
			valid_prev_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			ovp_prev_q <= ovp_q;
			input_undervoltage_prev_q <= input_undervoltage_q;
			valid_prev_q <= input_valid;
		end
	end

	// Interrupt pulse: events during a pulse are dropped so the host sees one edge per burst.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			pulse_cnt_q <= 13'h0000;
			int_o <= 1'b0;
		end
		else if (pulse_busy)
		begin
			pulse_cnt_q <= pulse_cnt_q - 13'h0001;
			int_o <= pulse_cnt_q != 13'h0001;
		end
		else if (fault_event)
		begin
			pulse_cnt_q <= 13'(PULSE_CNT);
			int_o <= 1'b1;
		end
	end

	// Sticky faults: set wins over a read, and a read clears only once the condition is gone.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			ovp_fault_o <= 1'b0;
			input_undervoltage_fault_o <= 1'b0;
		end
		else
		begin
			ovp_fault_o <= ovp_q || (ovp_fault_o && !fault_read_i);
			input_undervoltage_fault_o <= input_undervoltage_q || (input_undervoltage_fault_o && !fault_read_i);
		end
	end

	// Supplement hysteresis between entry and exit offsets.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			supplement_mode_o <= 1'b0;
		else if (sup_enter)
			supplement_mode_o <= 1'b1;
		else if (sup_exit)
			supplement_mode_o <= 1'b0;
	end

	// Host writes take priority over a concurrent default-mode entry.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
			default_mode_o <= 1'b1;
		else if (host_write_i)
			default_mode_o <= 1'b0;
		else if (reset_bit_i || (input_valid && !valid_prev_q))
			default_mode_o <= 1'b1;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			dpm_thresh_sel_o <= '0;
			dpm_active_o <= 1'b0;
			input_voltage_limit_flag_o <= 1'b0;
			timer_extend_o <= 1'b0;
			charge_enable_o <= 1'b0;
			discharge_switch_o <= 1'b1;
			term_done_o <= 1'b0;
			use_builtin_o <= 1'b0;
			term_code_o <= `CHGMF_TERM_DEF_CODE;
			precharge_code_o <= `CHGMF_TERM_DEF_CODE;
			ext_term_o <= 1'b0;
			ext_term_pct_o <= '0;
			ovp_status_o <= 1'b0;
			input_undervoltage_status_o <= 1'b0;
		end
		else
		begin
			dpm_thresh_sel_o <= dpm_sel_i;
			dpm_active_o <= dpm_act;
			input_voltage_limit_flag_o <= dpm_act;
			timer_extend_o <= double_timer_i && dpm_act;
			charge_enable_o <= state_d == CHGMF_ST_CHARGE;
			// Battery feeds the middle node in the fault state, or while the loop is active with a battery attached.
			discharge_switch_o <= state_d == CHGMF_ST_FAULT || no_chg_window;
			term_done_o <= state_d == CHGMF_ST_DONE;
			use_builtin_o <= default_mode_o && pin_gnd;
			term_code_o <= term_sel;
			precharge_code_o <= term_sel;
			ext_term_o <= ext_sel;
			ext_term_pct_o <= ext_term_pct_i;
			ovp_status_o <= ovp_q;
			input_undervoltage_status_o <= input_undervoltage_q;
		end
	end

	sequence s_ovp_rise;
		!ovp_prev_q && ovp_q && !pulse_busy;
	endsequence

	a_ovp_int_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		s_ovp_rise |=> int_o) else $error("Overvoltage gave no interrupt.");
	a_int_no_stretch: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(pulse_busy && fault_event) |=> pulse_cnt_q == $past(pulse_cnt_q) - 13'h0001)
		else $error("Pulse stretched.");
	a_fault_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(ovp_fault_o && !fault_read_i) |=> ovp_fault_o) else $error("Fault lost.");
	a_read_held: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		input_undervoltage_q |=> input_undervoltage_fault_o) else $error("Undervoltage flag cleared early.");
	a_term_blocked: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(state_q == CHGMF_ST_CHARGE && term_block) |=> !term_done_o)
		else $error("Termination while blocked.");
	a_cd_stops_chg: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		chg_off |=> !charge_enable_o) else $error("Charging while disabled.");
	a_limit_flag: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		dpm_act |=> input_voltage_limit_flag_o) else $error("Limit flag missed.");
	a_default_exit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		host_write_i |=> !default_mode_o) else $error("Default mode kept.");
	a_term_range: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		term_code_o <= `CHGMF_TERM_MAX_CODE) else $error("Termination code out of range.");
endmodule
`default_nettype wire

/* File: test/chgmf_host_model.sv */
// Host side model that watches the interrupt line and measures each pulse.
`timescale 1ns/1ps
`default_nettype none
module chgmf_host_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Interrupt line from the device
	input wire logic int_i,
	// Pulse statistics
	output logic [7:0] pulse_count_o,
	output logic [15:0] last_len_o
);
	logic [15:0] run_q;
	logic int_q;
	// A pulse is only counted on its falling edge, so a stretched pulse is seen as one long one.
	always_ff @(posedge clk_i)
	begin
		if (!rst_b_i)
		begin
			run_q <= 16'h0000;
			int_q <= 1'b0;
			pulse_count_o <= 8'h00;
			last_len_o <= 16'h0000;
		end
		else
		begin
			int_q <= int_i;
			run_q <= int_i ? run_q + 16'h0001 : 16'h0000;
			if (int_q && !int_i)
			begin
				pulse_count_o <= pulse_count_o + 8'h01;
				last_len_o <= run_q;
			end
		end
	end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking testbench for the charger mode and fault control block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import chgmf_pkg::*;
	localparam int DGL = 8;
	localparam int PULSE = 2560;
	logic clk_i, rst_b_i, ov, uv, below, bat, mbe, mae, ppr, cat, bar, cdp, pgnd;
	logic [1:0] loop;
	logic hw, fr, rb, cdb, dd, te, dt, uet;
	logic [2:0] sel;
	logic [6:0] tc;
	logic [1:0] pct;
	logic [2:0] dsel_o;
	logic [6:0] tc_o, pc_o;
	logic [1:0] pct_o;
	logic act_o, flag_o, ext_o, chg_o, dis_o, sup_o, done_o, def_o, bi_o, xt_o;
	logic ovs_o, uvs_o, ovf_o, uvf_o, int_o;
	logic [7:0] pcount;
	logic [15:0] plen;
	int bad_count, cmp_count, i;
	// Row: dpm disable, threshold select, input below threshold, expected loop active.
	logic [5:0] rows [10] = '{6'b0_000_1_1, 6'b0_001_1_1, 6'b0_010_1_1, 6'b0_011_1_1,
		6'b0_100_1_1, 6'b0_101_1_1, 6'b0_110_1_1, 6'b0_111_1_1, 6'b1_011_1_0, 6'b0_101_0_0};
	chgmf_top #(.PULSE_CYC(PULSE), .DGL_OVP_CYC(DGL), .DGL_INPUT_UNDERVOLTAGE_CYC(DGL)) chgmf_top_inst (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .input_overvoltage_i(ov), .input_undervoltage_i(uv),
		.input_below_dpm_i(below), .battery_attached_i(bat), .mid_below_bat_entry_i(mbe),
		.mid_above_bat_exit_i(mae), .power_path_reduction_mode_i(ppr), .current_at_term_i(cat),
		.bat_above_recharge_i(bar), .active_loop_i(loop), .charge_disable_pin_i(cdp),
		.prog_pin_grounded_i(pgnd), .host_write_i(hw), .fault_read_i(fr), .reset_bit_i(rb),
		.charge_disable_bit_i(cdb), .dpm_disable_i(dd), .dpm_sel_i(sel), .term_enable_i(te),
		.double_timer_i(dt), .term_code_i(tc), .use_ext_term_i(uet), .ext_term_pct_i(pct),
		.dpm_thresh_sel_o(dsel_o), .dpm_active_o(act_o), .input_voltage_limit_flag_o(flag_o),
		.timer_extend_o(xt_o), .charge_enable_o(chg_o), .discharge_switch_o(dis_o),
		.supplement_mode_o(sup_o), .term_done_o(done_o), .default_mode_o(def_o),
		.use_builtin_o(bi_o), .term_code_o(tc_o), .precharge_code_o(pc_o), .ext_term_o(ext_o),
		.ext_term_pct_o(pct_o), .ovp_status_o(ovs_o), .input_undervoltage_status_o(uvs_o),
		.ovp_fault_o(ovf_o), .input_undervoltage_fault_o(uvf_o), .int_o(int_o));
	chgmf_host_model chgmf_host_model_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .int_i(int_o),
		.pulse_count_o(pcount), .last_len_o(plen));
	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
	endtask
	task automatic conclude();
		if (bad_count == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#1500000;
		bad_count++;
		conclude();
	end
	initial
	begin
		{ov, uv, below, mbe, mae, ppr, cat, bar, cdp, pgnd, hw, fr, rb, cdb, dd, te, dt, uet} = '0;
		{bat, rst_b_i, loop, sel, tc, pct} = {1'b1, 1'b0, 2'h1, 3'h0, 7'h00, 2'h0};
		cyc(12);
		rst_b_i = 1'b1;
		chk("dis_rst", 16'h0001, {15'h0, dis_o});
		chk("def_rst", 16'h0001, {15'h0, def_o});
		chk("term_rst", 16'h0013, {9'h0, tc_o});
		chk("pre_rst", 16'h0013, {9'h0, pc_o});
		pgnd = 1'b1;
		cyc(4);
		chk("builtin", 16'h0001, {15'h0, bi_o});
		chk("ext_def", 16'h0000, {15'h0, ext_o});
		{tc, uet, pct, dt} = {7'h7f, 1'b1, 2'h3, 1'b1};
		pulse(hw);
		cyc(4);
		chk("def_exit", 16'h0000, {15'h0, def_o});
		chk("term_clip", 16'h0049, {9'h0, tc_o});
		chk("pre_eq", 16'h0049, {9'h0, pc_o});
		chk("ext_host", 16'h0001, {15'h0, ext_o});
		chk("ext_pct", 16'h0003, {14'h0, pct_o});
		chk("chg_on", 16'h0001, {15'h0, chg_o});
		for (i = 0; i < 10; i++)
		begin
			{dd, sel, below} = rows[i][5:1];
			cyc(5);
			chk("dpm_sel", {13'h0, rows[i][4:2]}, {13'h0, dsel_o});
			chk("dpm_act", {15'h0, rows[i][0]}, {15'h0, act_o});
			chk("dpm_ext", {15'h0, rows[i][0]}, {15'h0, xt_o});
			if (rows[i][0])
			begin
				chk("dpm_flag", 16'h0001, {15'h0, flag_o});
				chk("dpm_nochg", 16'h0000, {15'h0, chg_o});
				chk("dpm_mid", 16'h0001, {15'h0, dis_o});
			end
		end
		{te, cat, bar, ppr} = 4'hf;
		cyc(5);
		chk("term_ppr", 16'h0000, {15'h0, done_o});
		{ppr, loop} = 3'b0_00;
		cyc(5);
		chk("term_cc", 16'h0000, {15'h0, done_o});
		loop = 2'h2;
		cyc(5);
		chk("term_input_current_limit_setting", 16'h0000, {15'h0, done_o});
		{loop, below} = 3'b01_1;
		cyc(5);
		chk("term_dpm", 16'h0000, {15'h0, done_o});
		{below, mbe} = 2'b01;
		cyc(5);
		chk("sup_in", 16'h0001, {15'h0, sup_o});
		chk("term_sup", 16'h0000, {15'h0, done_o});
		mbe = 1'b0;
		cyc(5);
		chk("sup_hold", 16'h0001, {15'h0, sup_o});
		mae = 1'b1;
		cyc(5);
		chk("sup_out", 16'h0000, {15'h0, sup_o});
		chk("term_cv", 16'h0001, {15'h0, done_o});
		chk("term_off", 16'h0000, {15'h0, chg_o});
		{te, cat, mae, cdp} = 4'b0001;
		cyc(5);
		chk("pin_dis", 16'h0000, {15'h0, chg_o});
		chk("pin_hold", 16'h0000, {15'h0, done_o});
		{cdp, cdb} = 2'b01;
		cyc(5);
		chk("bit_dis", 16'h0000, {15'h0, chg_o});
		chk("bit_sw", 16'h0000, {15'h0, dis_o});
		ov = 1'b1;
		cyc(DGL + 6);
		chk("ovp_int", 16'h0001, {15'h0, int_o});
		chk("ovp_st", 16'h0001, {15'h0, ovs_o});
		chk("ovp_sw", 16'h0001, {15'h0, dis_o});
		uv = 1'b1;
		cyc(DGL + 6);
		chk("uv_flag", 16'h0001, {15'h0, uvf_o});
		chk("uv_st", 16'h0001, {15'h0, uvs_o});
		pulse(fr);
		cyc(2);
		chk("ovf_keep", 16'h0001, {15'h0, ovf_o});
		for (i = 0; i < 3000 && int_o !== 1'b0; i++)
			cyc(1);
		cyc(2);
		chk("int_cnt", 16'h0001, {8'h0, pcount});
		chk("int_len", 16'(PULSE), plen);
		{ov, uv} = 2'b00;
		cyc(DGL + 6);
		chk("ovs_clr", 16'h0000, {15'h0, ovs_o});
		chk("ovp_sw_off", 16'h0000, {15'h0, dis_o});
		chk("ovf_stay", 16'h0001, {15'h0, ovf_o});
		pulse(fr);
		cyc(2);
		chk("ovf_clr", 16'h0000, {15'h0, ovf_o});
		chk("uvf_clr", 16'h0000, {15'h0, uvf_o});
		uv = 1'b1;
		for (i = 0; i < 3000 && pcount !== 8'h02; i++)
			cyc(1);
		chk("uv_int", 16'h0002, {8'h0, pcount});
		chk("uv_len", 16'(PULSE), plen);
		pulse(hw);
		chk("def_hw", 16'h0000, {15'h0, def_o});
		uv = 1'b0;
		cyc(DGL + 6);
		chk("def_vin", 16'h0001, {15'h0, def_o});
		pulse(hw);
		chk("def_off", 16'h0000, {15'h0, def_o});
		pulse(rb);
		cyc(2);
		chk("def_rb", 16'h0001, {15'h0, def_o});
		rst_b_i = 1'b0;
		cyc(2);
		chk("dis_rst2", 16'h0001, {15'h0, dis_o});
		chk("uvf_rst2", 16'h0000, {15'h0, uvf_o});
		rst_b_i = 1'b1;
		cyc(4);
		chk("dis_run2", 16'h0000, {15'h0, dis_o});
		conclude();
	end
endmodule
`default_nettype wire
